/* src/rcoc_defines.vh */
// Purpose: constants for the rc oscillation converter (two 16-bit up-counters)
// Assumes: 8-bit register port, system clock 125 MHz, one clock domain
// Notes: byte-wide registers sit at their own byte addresses
// Operation
// - two independent 16-bit up-counters, timer a and timer b
// - mode register bit 1 enables the converter function
// - timer b counts rc oscillator rising edges, timer a the selected internal clock
// - clock select bits 7:5, 000 system clock, 001 system clock / 4, others unused
// - mode bit 0 picks the interrupt source, 0 timer a, 1 timer b
// - selected overflow sets flag bit 4 of second_interrupt_control and interrupts
// - any overflow stops both counters and clears the count enable together
// - clock control bit 4 is the count enable
// - with count enable and mode bit 1 set timer b and, for clock select 000 or 001, timer a run from loaded values until overflow
// - low-byte write only fills the shared low byte buffer
// - high-byte write loads high byte and buffered low byte together
// - high-byte read returns high byte and latches low byte; low read returns buffer
// - while count enable is one the timer byte registers are locked
// - clock control bits 2:0 read zero, bit 3 is plain storage
// - mode bits 3:2 read zero, bits 7:4 plain storage
`ifndef RCOC_DEFINES_VH
`define RCOC_DEFINES_VH

// register addresses
`define RCOC_ADDR_TA_LO    8'h20
`define RCOC_ADDR_TA_HI    8'h21
`define RCOC_ADDR_CLK_CTRL 8'h22
`define RCOC_ADDR_TB_LO    8'h23
`define RCOC_ADDR_TB_HI    8'h24
`define RCOC_ADDR_MODE     8'h25
`define RCOC_ADDR_IRQ_STAT 8'h26
`define RCOC_ADDR_IRQ_MASK 8'h27

// clock control fields
`define RCOC_CC_SPARE      3
`define RCOC_CC_EN         4
`define RCOC_CC_SEL_LO     5
`define RCOC_CC_SEL_HI     7
`define RCOC_CC_RMASK      8'hf8
`define RCOC_CC_RST        8'h08

// mode fields
`define RCOC_MD_OVB        0
`define RCOC_MD_EN         1
`define RCOC_MD_RMASK      8'hf3
`define RCOC_MD_RST        8'h80
`define RCOC_MD_GP_LO      4
`define RCOC_MD_GP_HI      7

// interrupt status and mask layout
`define RCOC_ST_OVA        0
`define RCOC_ST_OVB        1
`define RCOC_ST_CONV       4
`define RCOC_ST_RMASK      8'h13
`define RCOC_ST_RST        8'h00

// timer a clock selection
`define RCOC_SEL_SYS       3'h0
`define RCOC_SEL_DIV4      3'h1
`define RCOC_PRE_LAST      2'h3
`define RCOC_PRE_RST       2'h0

// counter values
`define RCOC_CNT_MAX       16'hffff
`define RCOC_CNT_RST       16'h0000
`define RCOC_BYTE_RST      8'h00

`endif

/* src/rcoc_sync.v */
// Purpose: brings the rc oscillator pin into the system clock domain
// Assumes: pin toggles well below a quarter of the system clock
// Notes: rise is a one-cycle pulse per accepted low-to-high change
`timescale 1ns/1ps
module rcoc_sync (
    // clock and reset
    input  wire clk,
    input  wire rst_n,
    // pin side
    input  wire pin,
    // system side
    output wire rise
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg level_q;

    // a change counts only once stages two and three agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign rise = (s2_q == s3_q) & s3_q & ~level_q;
endmodule

/* src/rcoc_cnt16.v */
// Purpose: one 16-bit up-counter with parallel load
// Assumes: load and inc are never both wanted; load wins
// Notes: wrap flags the increment from all ones to zero in the same cycle
`timescale 1ns/1ps
`include "rcoc_defines.vh"
module rcoc_cnt16 (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // control
    input  wire        load,
    input  wire [15:0] load_val,
    input  wire        inc,
    // state
    output wire [15:0] count,
    output wire        wrap
);
    reg [15:0] count_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= `RCOC_CNT_RST;
        end else if (load) begin
            count_q <= load_val;
        end else if (inc) begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign count = count_q;
    assign wrap  = inc & ~load & (count_q == `RCOC_CNT_MAX);
endmodule

/* src/rcoc_top.v */
// Purpose: rc oscillation converter, timer a against rc-clocked timer b
// Assumes: one system clock; rc oscillator arrives asynchronously on a pin
// Notes: timer bytes go through one shared low byte buffer
`timescale 1ns/1ps
`include "rcoc_defines.vh"
module rcoc_top (
    // clock and reset
    input  wire       CLK,
    input  wire       RST_N,
    // register port
    input  wire [7:0] ADDR,
    input  wire [7:0] WR_DATA,
    input  wire       WR_EN,
    input  wire       RD_EN,
    output reg  [7:0] RD_DATA,
    // external rc oscillator
    input  wire       RC_OSC,
    // interrupt
    output reg        IRQ
);
    // control and status registers
    reg  [2:0]  clk_sel_q;
    reg  [2:0]  clk_sel_d;
    reg         count_en_q;
    reg         count_en_d;
    reg         cc_spare_q;
    reg         cc_spare_d;
    reg         ovf_src_q;
    reg         ovf_src_d;
    reg         mode_en_q;
    reg         mode_en_d;
    reg  [3:0]  mode_gp_q;
    reg  [3:0]  mode_gp_d;
    reg  [7:0]  irq_stat_q;
    reg  [7:0]  irq_stat_d;
    reg  [7:0]  irq_mask_q;
    reg  [7:0]  irq_mask_d;
    reg  [7:0]  low_buf_q;
    reg  [7:0]  low_buf_d;
    reg  [1:0]  pre_q;
    reg  [1:0]  pre_d;
    reg  [7:0]  rd_d;

    // event and load wiring
    wire        rc_rise;
    wire        counting;
    wire        tick_a;
    wire        tick_b;
    wire        wrap_a;
    wire        wrap_b;
    wire        stop;
    wire        locked;
    wire        load_a;
    wire        load_b;
    wire [15:0] cnt_a;
    wire [15:0] cnt_b;
    wire [15:0] load_val;
    wire [7:0]  stat_set;
    wire [7:0]  stat_clr;
    wire        wr_cc;
    wire        wr_md;

    // reset images of the two control registers, split into their fields on reset
    localparam [7:0] cc_rst_img = `RCOC_CC_RST;
    localparam [7:0] md_rst_img = `RCOC_MD_RST;

    // address match used by the write decode
    function hit;
        input [7:0] a;
        input [7:0] match;
        begin
            hit = (a == match);
        end
    endfunction

    // timer byte registers are reachable only while count enable is off
    function timer_ok;
        input [7:0] a;
        input [7:0] match;
        input       lock;
        begin
            timer_ok = (a == match) & ~lock;
        end
    endfunction

    rcoc_sync u_sync (
        .clk   (CLK),
        .rst_n (RST_N),
        .pin   (RC_OSC),
        .rise  (rc_rise)
    );

    assign locked   = count_en_q;
    assign counting = count_en_q & mode_en_q;

    // the prescaler only matters in the /4 setting; codes other than 000 and 001 never tick
    assign tick_a = counting &
                    ((clk_sel_q == `RCOC_SEL_SYS) |
                     ((clk_sel_q == `RCOC_SEL_DIV4) & (pre_q == `RCOC_PRE_LAST)));
    assign tick_b = counting & rc_rise;

    assign load_val = {WR_DATA, low_buf_q};
    assign load_a   = WR_EN & timer_ok(ADDR, `RCOC_ADDR_TA_HI, locked);
    assign load_b   = WR_EN & timer_ok(ADDR, `RCOC_ADDR_TB_HI, locked);

    rcoc_cnt16 u_timer_a (
        .clk      (CLK),
        .rst_n    (RST_N),
        .load     (load_a),
        .load_val (load_val),
        .inc      (tick_a),
        .count    (cnt_a),
        .wrap     (wrap_a)
    );

    rcoc_cnt16 u_timer_b (
        .clk      (CLK),
        .rst_n    (RST_N),
        .load     (load_b),
        .load_val (load_val),
        .inc      (tick_b),
        .count    (cnt_b),
        .wrap     (wrap_b)
    );

    // either wrap halts both timers at once
    assign stop = wrap_a | wrap_b;

    assign wr_cc = WR_EN & hit(ADDR, `RCOC_ADDR_CLK_CTRL);
    assign wr_md = WR_EN & hit(ADDR, `RCOC_ADDR_MODE);

    assign stat_set = {3'b000,
                       (ovf_src_q ? wrap_b : wrap_a),
                       2'b00,
                       wrap_b,
                       wrap_a};
    assign stat_clr = (WR_EN & hit(ADDR, `RCOC_ADDR_IRQ_STAT)) ?
                      (WR_DATA & `RCOC_ST_RMASK) : `RCOC_ST_RST;

    // clock control next state
    always @* begin
        clk_sel_d  = clk_sel_q;
        count_en_d = count_en_q;
        cc_spare_d = cc_spare_q;
        if (wr_cc) begin
            clk_sel_d  = WR_DATA[`RCOC_CC_SEL_HI:`RCOC_CC_SEL_LO];
            count_en_d = WR_DATA[`RCOC_CC_EN];
            cc_spare_d = WR_DATA[`RCOC_CC_SPARE];
        end
        // hardware clear beats a same-cycle software write
        if (stop) begin
            count_en_d = 1'b0;
        end
    end

    // mode register next state
    always @* begin
        ovf_src_d = ovf_src_q;
        mode_en_d = mode_en_q;
        mode_gp_d = mode_gp_q;
        if (wr_md) begin
            ovf_src_d = WR_DATA[`RCOC_MD_OVB];
            mode_en_d = WR_DATA[`RCOC_MD_EN];
            mode_gp_d = WR_DATA[`RCOC_MD_GP_HI:`RCOC_MD_GP_LO];
        end
    end

    // interrupt status: a set in the clearing cycle survives
    always @* begin
        irq_stat_d = (irq_stat_q & ~stat_clr) | stat_set;
        irq_mask_d = irq_mask_q;
        if (WR_EN & hit(ADDR, `RCOC_ADDR_IRQ_MASK)) begin
            irq_mask_d = WR_DATA & `RCOC_ST_RMASK;
        end
    end

    // divide-by-four restarts with each run so the first tick is a full period
    always @* begin
        if (counting) begin
            pre_d = pre_q + 2'h1;
        end else begin
            pre_d = `RCOC_PRE_RST;
        end
    end

    // shared low byte buffer
    always @* begin
        low_buf_d = low_buf_q;
        if (WR_EN & (timer_ok(ADDR, `RCOC_ADDR_TA_LO, locked) |
                     timer_ok(ADDR, `RCOC_ADDR_TB_LO, locked))) begin
            low_buf_d = WR_DATA;
        end
        if (RD_EN & timer_ok(ADDR, `RCOC_ADDR_TA_HI, locked)) begin
            low_buf_d = cnt_a[7:0];
        end
        if (RD_EN & timer_ok(ADDR, `RCOC_ADDR_TB_HI, locked)) begin
            low_buf_d = cnt_b[7:0];
        end
    end

    // read mux; locked timer bytes and unmapped addresses answer zero
    always @* begin
        rd_d = `RCOC_BYTE_RST;
        if (RD_EN) begin
            case (ADDR)
                `RCOC_ADDR_TA_LO: begin
                    if (!locked) begin
                        rd_d = low_buf_q;
                    end
                end
                `RCOC_ADDR_TA_HI: begin
                    if (!locked) begin
                        rd_d = cnt_a[15:8];
                    end
                end
                `RCOC_ADDR_TB_LO: begin
                    if (!locked) begin
                        rd_d = low_buf_q;
                    end
                end
                `RCOC_ADDR_TB_HI: begin
                    if (!locked) begin
                        rd_d = cnt_b[15:8];
                    end
                end
                `RCOC_ADDR_CLK_CTRL: begin
                    rd_d = {clk_sel_q, count_en_q, cc_spare_q, 3'b000} &
                           `RCOC_CC_RMASK;
                end
                `RCOC_ADDR_MODE: begin
                    rd_d = {mode_gp_q, 2'b00, mode_en_q, ovf_src_q} &
                           `RCOC_MD_RMASK;
                end
                `RCOC_ADDR_IRQ_STAT: begin
                    rd_d = irq_stat_q;
                end
                `RCOC_ADDR_IRQ_MASK: begin
                    rd_d = irq_mask_q;
                end
                default: begin
                    rd_d = `RCOC_BYTE_RST;
                end
            endcase
        end
    end

    // all state registers
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_sel_q  <= cc_rst_img[`RCOC_CC_SEL_HI:`RCOC_CC_SEL_LO];
            count_en_q <= cc_rst_img[`RCOC_CC_EN];
            cc_spare_q <= cc_rst_img[`RCOC_CC_SPARE];
            ovf_src_q  <= md_rst_img[`RCOC_MD_OVB];
            mode_en_q  <= md_rst_img[`RCOC_MD_EN];
            mode_gp_q  <= md_rst_img[`RCOC_MD_GP_HI:`RCOC_MD_GP_LO];
            irq_stat_q <= `RCOC_ST_RST;
            irq_mask_q <= `RCOC_ST_RST;
            low_buf_q  <= `RCOC_BYTE_RST;
            pre_q      <= `RCOC_PRE_RST;
            RD_DATA    <= `RCOC_BYTE_RST;
            IRQ        <= 1'b0;
        end else begin
            clk_sel_q  <= clk_sel_d;
            count_en_q <= count_en_d;
            cc_spare_q <= cc_spare_d;
            ovf_src_q  <= ovf_src_d;
            mode_en_q  <= mode_en_d;
            mode_gp_q  <= mode_gp_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            low_buf_q  <= low_buf_d;
            pre_q      <= pre_d;
            RD_DATA    <= rd_d;
            // level output follows the next status so it tracks without lag
            IRQ        <= |(irq_stat_d & irq_mask_d);
        end
    end
endmodule

/* tb/rcoc_rc_model.sv */
// Purpose: behavioural rc oscillator network in front of the converter pin
// Assumes: oscillates only while run is high
// Notes: half period is kept unrelated to the system clock on purpose
`timescale 1ns/1ps
module rcoc_rc_model #(
    parameter real HALF_NS = 43.7
) (
    // control
    input  wire  run,
    // pin
    output logic osc
);
    initial osc = 1'b0;
    // parks low when stopped so no stray rise reaches timer b
    always begin
        wait (run);
        #HALF_NS osc = ~osc;
        if (!run)
            osc = 1'b0;
    end
endmodule

/* tb/rcoc_asserts.sv */
// Purpose: port-level checks of the rc oscillation converter
// Assumes: read data stand only in the cycle after the read strobe
// Notes: sees the top module ports only
`timescale 1ns/1ps
module rcoc_asserts (
    // clock and reset
    input wire       CLK,
    input wire       RST_N,
    // register port
    input wire [7:0] ADDR,
    input wire [7:0] WR_DATA,
    input wire       WR_EN,
    input wire       RD_EN,
    input wire [7:0] RD_DATA,
    // pins
    input wire       RC_OSC,
    input wire       IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire tmr = (ADDR == 8'h20) || (ADDR == 8'h21) || (ADDR == 8'h23) || (ADDR == 8'h24);

    property p_rd_idle;
        !$past(RD_EN) |-> RD_DATA == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    property p_cc_zero;
        RD_EN && ADDR == 8'h22 |=> RD_DATA[2:0] == 3'h0;
    endproperty
    a_cc_zero: assert property (p_cc_zero) else $error("clock control low bits not zero");
    property p_md_zero;
        RD_EN && ADDR == 8'h25 |=> RD_DATA[3:2] == 2'h0;
    endproperty
    a_md_zero: assert property (p_md_zero) else $error("mode bits 3:2 not zero");
    property p_cc_spare;
        WR_EN && ADDR == 8'h22 ##1 RD_EN && ADDR == 8'h22 |=> RD_DATA[3] == $past(WR_DATA[3], 2);
    endproperty
    a_cc_spare: assert property (p_cc_spare) else $error("spare bit not stored");
    property p_md_store;
        WR_EN && ADDR == 8'h25 ##1 RD_EN && ADDR == 8'h25 |=> RD_DATA == ($past(WR_DATA, 2) & 8'hf3);
    endproperty
    a_md_store: assert property (p_md_store) else $error("mode readback wrong");
    property p_lock;
        WR_EN && ADDR == 8'h22 && WR_DATA[4] ##1 RD_EN && tmr |=> RD_DATA == 8'h00;
    endproperty
    a_lock: assert property (p_lock) else $error("timer byte readable while counting");
    property p_mask_off;
        WR_EN && ADDR == 8'h27 && WR_DATA == 8'h00 ##1 !(WR_EN && ADDR == 8'h27) |=> !IRQ;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("interrupt with all masked");
    property p_st_layout;
        RD_EN && (ADDR == 8'h26 || ADDR == 8'h27) |=> (RD_DATA & 8'hec) == 8'h00;
    endproperty
    a_st_layout: assert property (p_st_layout) else $error("status layout wrong");
endmodule

bind rcoc_top rcoc_asserts u_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN),
    .RD_EN(RD_EN), .RD_DATA(RD_DATA), .RC_OSC(RC_OSC), .IRQ(IRQ));

/* tb/rcoc_tb_top.sv */
// Purpose: self-checking bench for the rc oscillation converter
// Assumes: register port with one-cycle strobes
// Notes: no wait is open-ended
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module rcoc_tb_top;
    logic       clk, rst_n, wen, ren, run;
    logic [7:0] addr, wdat;
    wire  [7:0] rdat;
    wire        rc, irq;
    int         fails, n_compared, n;

    rcoc_top dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wdat), .WR_EN(wen), .RD_EN(ren),
        .RD_DATA(rdat), .RC_OSC(rc), .IRQ(irq));
    rcoc_rc_model #(.HALF_NS(43.7)) u_rc (.run(run), .osc(rc));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wen  <= 1'b1;
        @(posedge clk);
        wen  <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        ren  <= 1'b1;
        @(posedge clk);
        ren  <= 1'b0;
        #1;
        `CHK(rdat, e)
    endtask
    // write then read with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] ra, input logic [7:0] e);
        wr(a, d);
        addr <= ra;
        ren  <= 1'b1;
        @(posedge clk);
        ren  <= 1'b0;
        #1;
        `CHK(rdat, e)
    endtask
    task automatic ld(input logic [7:0] hi, input logic [15:0] v);
        wr(hi - 8'h01, v[7:0]);
        wr(hi, v[15:8]);
    endtask
    task automatic wait_irq(output int k);
        k = 0;
        while (irq !== 1'b1) begin
            @(posedge clk);
            #1;
            k++;
            if (k > 900) begin
                fails++;
                tally_and_finish();
            end
        end
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, e)
    endtask

    task automatic t_reset();
        rd(8'h22, 8'h08);
        rd(8'h25, 8'h80);
        rd(8'h26, 8'h00);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
    endtask
    task automatic t_regs();
        wr_rd(8'h22, 8'hef, 8'h22, 8'he8);
        wr_rd(8'h25, 8'hff, 8'h25, 8'hf3);
        wr_rd(8'h22, 8'h08, 8'h22, 8'h08);
    endtask
    task automatic t_buffer();
        wr(8'h20, 8'h34);
        rd(8'h21, 8'h00);
        wr(8'h20, 8'h34);
        wr(8'h21, 8'h12);
        rd(8'h21, 8'h12);
        rd(8'h20, 8'h34);
        ld(8'h24, 16'h5678);
        rd(8'h24, 8'h56);
        rd(8'h23, 8'h78);
        rd(8'h21, 8'h12);
        rd(8'h23, 8'h34);
    endtask
    task automatic t_ovf_a();
        wr(8'h25, 8'h02);
        ld(8'h21, 16'hfffe);
        ld(8'h24, 16'h0000);
        wr(8'h27, 8'h10);
        wr(8'h22, 8'h10);
        wait_irq(n);
        `CHK(n, 2)
        rd(8'h22, 8'h00);
        rd(8'h26, 8'h11);
        rd(8'h21, 8'h00);
        rd(8'h20, 8'h00);
        rd(8'h24, 8'h00);
        wr(8'h27, 8'h00);
        irq_is(1'b0);
        wr(8'h27, 8'h10);
        irq_is(1'b1);
        wr(8'h26, 8'h11);
        irq_is(1'b0);
        rd(8'h26, 8'h00);
    endtask
    task automatic t_lock();
        wr(8'h25, 8'h00);
        ld(8'h21, 16'hfffe);
        wr_rd(8'h22, 8'h10, 8'h21, 8'h00);
        wr(8'h20, 8'h55);
        repeat (10) @(posedge clk);
        rd(8'h22, 8'h10);
        wr(8'h22, 8'h00);
        rd(8'h21, 8'hff);
        rd(8'h20, 8'hfe);
    endtask
    task automatic t_div4();
        wr(8'h25, 8'h03);
        ld(8'h21, 16'hfff0);
        wr(8'h27, 8'h01);
        wr(8'h22, 8'h30);
        wait_irq(n);
        `CHK((n >= 64 && n <= 66), 1'b1)
        rd(8'h26, 8'h01);
        wr(8'h26, 8'h13);
    endtask
    task automatic t_rc_b();
        ld(8'h24, 16'hfffd);
        ld(8'h21, 16'h0000);
        wr(8'h27, 8'h12);
        wr(8'h22, 8'h50);
        run = 1'b1;
        wait_irq(n);
        run = 1'b0;
        rd(8'h26, 8'h12);
        rd(8'h21, 8'h00);
        rd(8'h24, 8'h00);
        rd(8'h23, 8'h00);
    endtask

    initial begin
        rst_n      = 1'b0;
        addr       = 8'h00;
        wdat       = 8'h00;
        wen        = 1'b0;
        ren        = 1'b0;
        run        = 1'b0;
        fails      = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_buffer();
        t_ovf_a();
        t_lock();
        t_div4();
        t_rc_b();
        tally_and_finish();
    end
endmodule
